// >>> mdi_pkg.sv
// shared constants of the motor driver two-wire target and its host end
// assumes both ends run on clk_sys at the rate given below

package mdi_pkg;
  // ----------------------------------------
  // clock and link timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_FREQ_KHZ = 100;
  localparam int SCL_PERIOD_NS = 1000000 / SCL_FREQ_KHZ;
  localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  // longest command-to-action times, rounded down to whole cycles
  localparam int SH_START_MAX_US = 10;
  localparam int SH_START_MAX_CYC = SH_START_MAX_US * 1000 / CLK_PERIOD_NS;
  localparam real FOCUS_START_MAX_MS = 1.2;
  localparam int FOCUS_START_MAX_CYC = int'($floor(FOCUS_START_MAX_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int HOME_START_MAX_MS = 6;
  localparam int HOME_START_MAX_CYC = HOME_START_MAX_MS * 1000000 / CLK_PERIOD_NS;

  // ----------------------------------------
  // framing and addressing
  // ----------------------------------------
  localparam logic [6:0] TGT_ADDR = 7'h32;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------
  // command words (register pointer, then data)
  // ----------------------------------------
  localparam logic [7:0] REG_FOCUS = 8'h00;
  localparam logic [7:0] REG_HOME = 8'h01;
  localparam logic [7:0] REG_SHUTTER = 8'h02;
  localparam logic [7:0] REG_CURRENT = 8'h03;
  localparam int FOCUS_ON_BIT = 1;
  localparam int HOME_ON_BIT = 4;
  localparam int SH_ON_BIT = 2;
  localparam int BUSY_BIT = 7;

  // ----------------------------------------
  // actions and reset values
  // ----------------------------------------
  localparam int NUM_ACT = 3;
  localparam int ACT_SHUTTER = 0;
  localparam int ACT_FOCUS = 1;
  localparam int ACT_HOME = 2;
  localparam logic [3:0] CUR_CODE_RST = 4'h0;
  localparam logic [1:0] SH_MODE_RST = 2'h0;
  localparam logic [8:0] CUR_BASE_MA = 9'h104;
  localparam logic [8:0] CUR_STEP_MA = 9'h00a;

  // drive level in mA for a current code
  function automatic logic [8:0] mdi_cur_ma(input logic [3:0] code);
    logic [8:0] prod;
    prod = 9'(CUR_STEP_MA * code);
    return CUR_BASE_MA - prod;
  endfunction
endpackage

// >>> mdi_link_if.sv
// two-wire link between host end and target end
// assumes a pull-up on both lines: a line is low only while some end drives it low

`timescale 1ns/1ps

interface mdi_link_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_t_o;
  logic sda_t_oe;
  logic scl;
  logic sda;

  // ----------------------------------------
  // wired-and resolution with pull-up
  // ----------------------------------------
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_t_oe && !sda_t_o));

  modport host (output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
  modport target (output sda_t_o, output sda_t_oe, input scl, input sda);
endinterface

// >>> mdi_host.sv
// host end: two-wire bus master issuing register writes and status reads
// assumes the target never stretches the clock; scl is made here by a divider

`timescale 1ns/1ps

module mdi_host import mdi_pkg::*; #(
  parameter int QTR_CYC = SCL_QTR_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  mdi_link_if.host link,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_reg,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic done,
  output logic nack,
  output logic [7:0] rd_data
);
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} mdi_hst_e;

  if (QTR_CYC < 4 || QTR_CYC > 65535) begin : g_bad_qtr
    $error("mdi_host: QTR_CYC out of range");
  end

  mdi_hst_e st_ff, nxt_st;
  logic [15:0] div_ff, nxt_div;
  logic [1:0] q_ff, nxt_q;
  logic [1:0] byte_ff, nxt_byte;
  logic [3:0] bit_ff, nxt_bit;
  logic rd_ff, nxt_rd;
  logic [7:0] reg_ff, nxt_reg;
  logic [7:0] dat_ff, nxt_dat;
  logic [7:0] rx_ff, nxt_rx;
  logic nack_ff, nxt_nack;
  logic done_ff, nxt_done;
  logic ready_ff, nxt_ready;
  logic scl_oe_ff, nxt_scl_oe;
  logic sda_oe_ff, nxt_sda_oe;
  logic [7:0] rdata_ff, nxt_rdata;
  logic [1:0] sda_sy_ff;
  logic tick;
  logic rx_byte;
  logic [1:0] last_byte;

  // pull low for a zero data bit; released for ones, acks and read bytes
  function automatic logic drive_low(input logic [1:0] b, input logic [3:0] i, input logic rd,
                                     input logic [7:0] rg, input logic [7:0] dt);
    logic [7:0] v;
    v = (b == 2'h0) ? {TGT_ADDR, rd} : ((b == 2'h1) ? rg : dt);
    return (i < BITS_PER_BYTE) && !(rd && b == 2'h1) && !v[3'(4'h7 - i)];
  endfunction

  assign tick = (div_ff == 16'(QTR_CYC - 1));
  assign rx_byte = rd_ff && (byte_ff == 2'h1);
  assign last_byte = rd_ff ? 2'h1 : 2'h2;

  // ----------------------------------------
  // bit engine, four quarters per scl period
  // ----------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_div = (st_ff == H_IDLE || tick) ? 16'h0000 : div_ff + 16'h0001;
    nxt_q = tick ? q_ff + 2'h1 : q_ff;
    nxt_byte = byte_ff;
    nxt_bit = bit_ff;
    nxt_rd = rd_ff;
    nxt_reg = reg_ff;
    nxt_dat = dat_ff;
    nxt_rx = rx_ff;
    nxt_nack = nack_ff;
    nxt_done = 1'b0;
    nxt_ready = ready_ff;
    nxt_scl_oe = scl_oe_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_rdata = rdata_ff;
    unique case (st_ff)
      H_IDLE: begin
        nxt_scl_oe = 1'b0;
        nxt_sda_oe = 1'b0;
        nxt_q = 2'h0;
        if (cmd_valid) begin
          nxt_st = H_START;
          nxt_rd = cmd_read;
          nxt_reg = cmd_reg;
          nxt_dat = cmd_data;
          nxt_nack = 1'b0;
          nxt_ready = 1'b0;
        end
      end
      H_START: begin
        if (tick && q_ff == 2'h0) nxt_sda_oe = 1'b1;
        if (tick && q_ff == 2'h2) nxt_scl_oe = 1'b1;
        if (tick && q_ff == 2'h3) begin
          nxt_st = H_BIT;
          nxt_byte = 2'h0;
          nxt_bit = 4'h0;
          nxt_sda_oe = drive_low(2'h0, 4'h0, rd_ff, reg_ff, dat_ff);
        end
      end
      H_BIT: begin
        if (tick && q_ff == 2'h0) nxt_scl_oe = 1'b0;
        if (tick && q_ff == 2'h1) begin
          if (bit_ff < BITS_PER_BYTE && rx_byte) nxt_rx = {rx_ff[6:0], sda_sy_ff[1]};
          if (bit_ff == BITS_PER_BYTE && !rx_byte && sda_sy_ff[1]) nxt_nack = 1'b1;
        end
        if (tick && q_ff == 2'h2) nxt_scl_oe = 1'b1;
        // sda changes only with scl low
        if (tick && q_ff == 2'h3) begin
          if (bit_ff == BITS_PER_BYTE) begin
            if (nack_ff || byte_ff == last_byte) begin
              nxt_st = H_STOP;
              nxt_sda_oe = 1'b1;
            end else begin
              nxt_byte = byte_ff + 2'h1;
              nxt_bit = 4'h0;
              nxt_sda_oe = drive_low(byte_ff + 2'h1, 4'h0, rd_ff, reg_ff, dat_ff);
            end
          end else begin
            nxt_bit = bit_ff + 4'h1;
            nxt_sda_oe = drive_low(byte_ff, bit_ff + 4'h1, rd_ff, reg_ff, dat_ff);
          end
        end
      end
      H_STOP: begin
        if (tick && q_ff == 2'h0) nxt_scl_oe = 1'b0;
        if (tick && q_ff == 2'h1) nxt_sda_oe = 1'b0;
        if (tick && q_ff == 2'h3) begin
          nxt_st = H_IDLE;
          nxt_done = 1'b1;
          nxt_ready = 1'b1;
          nxt_rdata = rx_ff;
        end
      end
    endcase
  end

  // ----------------------------------------
  // registers; sda is a pin so it is synchronised first
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= H_IDLE;
      div_ff <= 16'h0000;
      q_ff <= 2'h0;
      byte_ff <= 2'h0;
      bit_ff <= 4'h0;
      rd_ff <= 1'b0;
      reg_ff <= 8'h00;
      dat_ff <= 8'h00;
      rx_ff <= 8'h00;
      nack_ff <= 1'b0;
      done_ff <= 1'b0;
      ready_ff <= 1'b1;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      rdata_ff <= 8'h00;
      sda_sy_ff <= 2'h3;
    end else begin
      st_ff <= nxt_st;
      div_ff <= nxt_div;
      q_ff <= nxt_q;
      byte_ff <= nxt_byte;
      bit_ff <= nxt_bit;
      rd_ff <= nxt_rd;
      reg_ff <= nxt_reg;
      dat_ff <= nxt_dat;
      rx_ff <= nxt_rx;
      nack_ff <= nxt_nack;
      done_ff <= nxt_done;
      ready_ff <= nxt_ready;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      rdata_ff <= nxt_rdata;
      sda_sy_ff <= {sda_sy_ff[0], link.sda};
    end
  end

  // open-drain: the output value is always low, only the enables move
  assign link.scl_m_o = 1'b0;
  assign link.sda_m_o = 1'b0;
  assign link.scl_m_oe = scl_oe_ff;
  assign link.sda_m_oe = sda_oe_ff;
  assign cmd_ready = ready_ff;
  assign done = done_ff;
  assign nack = nack_ff;
  assign rd_data = rdata_ff;
endmodule // mdi_host

// >>> mdi_target.sv
// target end: two-wire slave of the lens and shutter motor driver
// assumes scl and sda arrive asynchronously and far slower than clk_sys

`timescale 1ns/1ps

module mdi_target import mdi_pkg::*; #(
  parameter int SH_DLY_CYC = 16,
  parameter int FOCUS_DLY_CYC = 16,
  parameter int HOME_DLY_CYC = 16,
  parameter int FOCUS_MAX_CYC = FOCUS_START_MAX_CYC,
  parameter int HOME_MAX_CYC = HOME_START_MAX_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  mdi_link_if.target link,
  input wire logic chip_enable_pin,
  input wire logic seq_busy,
  output logic shutter_start,
  output logic focus_start,
  output logic home_start,
  output logic shutter_on,
  output logic [1:0] shutter_mode,
  output logic current_bridge_out_a,
  output logic current_bridge_out_b,
  output logic [3:0] current_code,
  output logic [8:0] current_ma
);
  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_AACK, T_RX, T_RACK, T_TX, T_TACK, T_SKIP} mdi_tst_e;

  localparam int DLY [NUM_ACT] = '{SH_DLY_CYC, FOCUS_DLY_CYC, HOME_DLY_CYC};

  if (SH_DLY_CYC < 1 || SH_DLY_CYC + 3 > SH_START_MAX_CYC) begin : g_bad_sh
    $error("mdi_target: SH_DLY_CYC too long");
  end
  if (FOCUS_DLY_CYC < 1 || FOCUS_DLY_CYC + 3 > FOCUS_MAX_CYC || FOCUS_DLY_CYC > 1048575) begin : g_bad_af
    $error("mdi_target: FOCUS_DLY_CYC too long");
  end
  if (HOME_DLY_CYC < 1 || HOME_DLY_CYC + 3 > HOME_MAX_CYC || HOME_DLY_CYC > 1048575) begin : g_bad_hp
    $error("mdi_target: HOME_DLY_CYC too long");
  end

  // ----------------------------------------
  // pin synchronisers and line events
  // ----------------------------------------
  logic [2:0] scl_sy_ff, nxt_scl_sy;
  logic [2:0] sda_sy_ff, nxt_sda_sy;
  logic [1:0] ena_sy_ff, nxt_ena_sy;
  logic scl_s, scl_d, sda_s, sda_d;
  logic start_det, stop_det, scl_rise, scl_fall;

  // stage 0 feeds only stage 1; events look at stages 1 and 2
  always_comb begin
    nxt_scl_sy = {scl_sy_ff[1:0], link.scl};
    nxt_sda_sy = {sda_sy_ff[1:0], link.sda};
    nxt_ena_sy = {ena_sy_ff[0], chip_enable_pin};
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scl_sy_ff <= 3'h7;
      sda_sy_ff <= 3'h7;
      ena_sy_ff <= 2'h0;
    end else begin
      scl_sy_ff <= nxt_scl_sy;
      sda_sy_ff <= nxt_sda_sy;
      ena_sy_ff <= nxt_ena_sy;
    end
  end

  assign scl_s = scl_sy_ff[1];
  assign scl_d = scl_sy_ff[2];
  assign sda_s = sda_sy_ff[1];
  assign sda_d = sda_sy_ff[2];
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;

  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  mdi_tst_e st_ff, nxt_st;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [7:0] shift_ff, nxt_shift;
  logic [7:0] ptr_ff, nxt_ptr;
  logic have_ptr_ff, nxt_have_ptr;
  logic rw_ff, nxt_rw;
  logic sda_oe_ff, nxt_sda_oe;
  logic wr_go;
  logic [7:0] status;

  always_comb begin
    status = 8'h00;
    status[BUSY_BIT] = seq_busy;
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_have_ptr = have_ptr_ff;
    nxt_rw = rw_ff;
    nxt_sda_oe = sda_oe_ff;
    wr_go = 1'b0;
    if (!ena_sy_ff[1]) begin
      nxt_st = T_IDLE;
      nxt_sda_oe = 1'b0;
    end else if (start_det) begin
      nxt_st = T_ADDR;
      nxt_cnt = 4'h0;
      nxt_have_ptr = 1'b0;
      nxt_sda_oe = 1'b0;
    end else if (stop_det) begin
      nxt_st = T_IDLE;
      nxt_sda_oe = 1'b0;
    end else begin
      unique case (st_ff)
        T_IDLE, T_SKIP: begin
          // foreign access ignored until stop or start
          nxt_sda_oe = 1'b0;
        end
        T_ADDR, T_RX: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_cnt = cnt_ff + 4'h1;
          end
          if (scl_fall && cnt_ff == BITS_PER_BYTE) begin
            if (st_ff == T_ADDR) begin
              if (shift_ff[7:1] == TGT_ADDR) begin
                nxt_rw = shift_ff[0];
                nxt_sda_oe = 1'b1;
                nxt_st = T_AACK;
              end else begin
                nxt_st = T_SKIP;
              end
            end else begin
              nxt_sda_oe = 1'b1;
              nxt_st = T_RACK;
              if (!have_ptr_ff) begin
                nxt_ptr = shift_ff;
                nxt_have_ptr = 1'b1;
              end else begin
                wr_go = 1'b1;
                nxt_ptr = ptr_ff + 8'h01;
              end
            end
          end
        end
        T_AACK: begin
          if (scl_fall) begin
            if (rw_ff) begin
              nxt_shift = status;
              nxt_sda_oe = !status[7];
              nxt_cnt = 4'h1;
              nxt_st = T_TX;
            end else begin
              nxt_sda_oe = 1'b0;
              nxt_cnt = 4'h0;
              nxt_st = T_RX;
            end
          end
        end
        T_RACK: begin
          if (scl_fall) begin
            nxt_sda_oe = 1'b0;
            nxt_cnt = 4'h0;
            nxt_st = T_RX;
          end
        end
        T_TX: begin
          // next bit set only after scl falls
          if (scl_fall) begin
            if (cnt_ff == BITS_PER_BYTE) begin
              nxt_sda_oe = 1'b0;
              nxt_st = T_TACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b1};
              nxt_sda_oe = !shift_ff[6];
              nxt_cnt = cnt_ff + 4'h1;
            end
          end
        end
        T_TACK: begin
          if (scl_rise && sda_s) nxt_st = T_SKIP;
          if (scl_fall) begin
            nxt_shift = status;
            nxt_sda_oe = !status[7];
            nxt_cnt = 4'h1;
            nxt_st = T_TX;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= T_IDLE;
      cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      have_ptr_ff <= 1'b0;
      rw_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      have_ptr_ff <= nxt_have_ptr;
      rw_ff <= nxt_rw;
      sda_oe_ff <= nxt_sda_oe;
    end
  end

  // ----------------------------------------
  // command decode and drive settings
  // ----------------------------------------
  logic [3:0] code_ff, nxt_code;
  logic [8:0] ma_ff, nxt_ma;
  logic [1:0] mode_ff, nxt_mode;
  logic sh_on_ff, nxt_sh_on;
  logic out_a_ff, nxt_out_a;
  logic out_b_ff, nxt_out_b;
  logic [NUM_ACT-1:0] act_req;

  // a write lands when the data byte is acked, so a refused byte never acts
  always_comb begin
    nxt_code = code_ff;
    nxt_mode = mode_ff;
    nxt_sh_on = sh_on_ff;
    act_req = '0;
    if (wr_go && ptr_ff == REG_CURRENT) nxt_code = shift_ff[3:0];
    if (wr_go && ptr_ff == REG_SHUTTER) begin
      nxt_mode = shift_ff[1:0];
      nxt_sh_on = shift_ff[SH_ON_BIT];
      act_req[ACT_SHUTTER] = 1'b1;
    end
    if (wr_go && ptr_ff == REG_FOCUS) act_req[ACT_FOCUS] = shift_ff[FOCUS_ON_BIT];
    if (wr_go && ptr_ff == REG_HOME) act_req[ACT_HOME] = shift_ff[HOME_ON_BIT];
    nxt_ma = mdi_cur_ma(nxt_code);
    nxt_out_a = nxt_sh_on && (nxt_mode == 2'h1);
    nxt_out_b = nxt_sh_on && (nxt_mode == 2'h2);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      code_ff <= CUR_CODE_RST;
      ma_ff <= CUR_BASE_MA;
      mode_ff <= SH_MODE_RST;
      sh_on_ff <= 1'b0;
      out_a_ff <= 1'b0;
      out_b_ff <= 1'b0;
    end else begin
      code_ff <= nxt_code;
      ma_ff <= nxt_ma;
      mode_ff <= nxt_mode;
      sh_on_ff <= nxt_sh_on;
      out_a_ff <= nxt_out_a;
      out_b_ff <= nxt_out_b;
    end
  end

  // ----------------------------------------
  // action launch delays, one counter each
  // ----------------------------------------
  // each launch flop lives in its own block so that no vector has several clocked writers
  for (genvar i = 0; i < NUM_ACT; i++) begin : g_act
    logic start_ff;
    logic [19:0] dly_ff, nxt_dly;
    logic pend_ff, nxt_pend;
    logic nxt_start;

    always_comb begin
      nxt_dly = dly_ff;
      nxt_pend = pend_ff;
      nxt_start = 1'b0;
      if (act_req[i]) begin
        nxt_pend = 1'b1;
        nxt_dly = 20'(DLY[i] - 1);
      end else if (pend_ff) begin
        if (dly_ff == 20'h00000) begin
          nxt_pend = 1'b0;
          nxt_start = 1'b1;
        end else begin
          nxt_dly = dly_ff - 20'h00001;
        end
      end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        dly_ff <= 20'h00000;
        pend_ff <= 1'b0;
        start_ff <= 1'b0;
      end else begin
        dly_ff <= nxt_dly;
        pend_ff <= nxt_pend;
        start_ff <= nxt_start;
      end
    end
  end

  // open-drain: value always low, enable pulls the line
  assign link.sda_t_o = 1'b0;
  assign link.sda_t_oe = sda_oe_ff;
  assign shutter_start = g_act[ACT_SHUTTER].start_ff;
  assign focus_start = g_act[ACT_FOCUS].start_ff;
  assign home_start = g_act[ACT_HOME].start_ff;
  assign shutter_on = sh_on_ff;
  assign shutter_mode = mode_ff;
  assign current_bridge_out_a = out_a_ff;
  assign current_bridge_out_b = out_b_ff;
  assign current_code = code_ff;
  assign current_ma = ma_ff;
endmodule // mdi_target

// >>> mdi_link_chk.sv
// link assertions for the two-wire host and target pair
// assumes one clk_sys domain and pulled-up lines
`timescale 1ns/1ps
module mdi_link_chk import mdi_pkg::*; (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic scl_m_oe,
  input wire logic sda_m_oe,
  input wire logic sda_t_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam int REL_MAX = 12;
  logic [3:0] bit_ff, nxt_bit;
  logic [7:0] sh_ff, nxt_sh;
  logic [1:0] byte_ff, nxt_byte;
  logic rw_ff, nxt_rw, scl_d_ff, sda_d_ff, rcv;
  // ------
  // position tracking
  // ------
  // bit 0 only right after start, so the start itself never counts as a bit
  always_comb begin
    nxt_bit = bit_ff;
    nxt_sh = sh_ff;
    nxt_byte = byte_ff;
    nxt_rw = rw_ff;
    if (scl && scl_d_ff && sda_d_ff && !sda) begin
      nxt_bit = 4'h0;
      nxt_byte = 2'h0;
    end else if (scl && !scl_d_ff) begin
      // 10 marks the first rise after an ack: bit 1 of the next byte, or the rise ahead of a stop
      nxt_bit = (bit_ff == 4'h9) ? 4'ha : ((bit_ff == 4'ha) ? 4'h2 : bit_ff + 4'h1);
      nxt_sh = {sh_ff[6:0], sda};
      if (bit_ff == 4'h9 && byte_ff != 2'h3) nxt_byte = byte_ff + 2'h1;
      if (bit_ff == 4'h7 && byte_ff == 2'h0) nxt_rw = sda;
    end
  end
  // registers of the tracker
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      byte_ff <= 2'h0;
      rw_ff <= 1'b0;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      bit_ff <= nxt_bit;
      sh_ff <= nxt_sh;
      byte_ff <= nxt_byte;
      rw_ff <= nxt_rw;
      scl_d_ff <= scl;
      sda_d_ff <= sda;
    end
  end
  // target receives its own address byte and every byte of a write
  assign rcv = (byte_ff == 2'h0) ? (sh_ff[7:1] == TGT_ADDR) : !rw_ff;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence ack_slot_s; $fell(scl) && bit_ff == 4'h8; endsequence
  sequence stop_s; $rose(sda) && scl && $past(scl); endsequence
  sequence start_s; $fell(sda) && scl && $past(scl); endsequence
  bus_idle_a: assert property (stop_s |-> (!scl_m_oe && !sda_m_oe && !sda_t_oe) [*8])
    else $error("line pulled after stop");
  start_clean_a: assert property (start_s |-> sda_m_oe && !sda_t_oe && (bit_ff == 4'h0 || bit_ff == 4'ha))
    else $error("bad start");
  tgt_stable_a: assert property (scl && $past(scl) |-> $stable(sda_t_oe))
    else $error("target moved sda with scl high");
  host_stable_a: assert property (scl && $changed(sda_m_oe) |-> (bit_ff == 4'h0 || bit_ff == 4'ha))
    else $error("host moved sda with scl high");
  stop_count_a: assert property (stop_s |-> bit_ff == 4'ha)
    else $error("partial byte at stop");
  ack_drive_a: assert property (ack_slot_s ##0 rcv |-> ##[1:3] sda_t_oe [*4])
    else $error("no acknowledge");
  host_release_a: assert property (ack_slot_s ##0 rcv |-> ##[1:REL_MAX] !sda_m_oe)
    else $error("host kept sda in ack slot");
  send_release_a: assert property (ack_slot_s ##0 (byte_ff != 2'h0 && rw_ff) |-> ##3 !sda_t_oe [*8])
    else $error("target kept sda after read byte");
  ack_release_a: assert property ($fell(scl) && bit_ff == 4'h9 && !rw_ff |-> ##3 !sda_t_oe [*8])
    else $error("ack not released");
endmodule // mdi_link_chk

// >>> motor_driver_i2c_target_tb.sv
// bench joining host and target ends over one link
// assumes the package constants and a 100 MHz clk_sys
`timescale 1ns/1ps
module motor_driver_i2c_target_tb import mdi_pkg::*; ;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0, cmd_read = 1'b0, chip_enable_pin = 1'b0, seq_busy = 1'b0;
  logic [7:0] cmd_reg = 8'h00, cmd_data = 8'h00, rd_data;
  logic cmd_ready, done, nack, shutter_start, focus_start, home_start, shutter_on;
  logic current_bridge_out_a, current_bridge_out_b;
  logic [1:0] shutter_mode;
  logic [3:0] current_code;
  logic [8:0] current_ma;
  logic [31:0] lfsr_q = 32'hf1e46247;
  int miscompares = 0, total_checks = 0;
  int n_act [3];
  logic [2:0] act_v;
  // start pulses gathered in action order
  assign act_v = {home_start, focus_start, shutter_start};
  mdi_link_if lnk ();
  // small quarter count keeps each transfer under a thousand cycles
  mdi_host #(.QTR_CYC(8)) mdi_host_inst (.clk_sys, .rst_b, .link(lnk), .cmd_valid, .cmd_read, .cmd_reg,
    .cmd_data, .cmd_ready, .done, .nack, .rd_data);
  mdi_target mdi_target_inst (.clk_sys, .rst_b, .link(lnk), .chip_enable_pin, .seq_busy, .shutter_start,
    .focus_start, .home_start, .shutter_on, .shutter_mode, .current_bridge_out_a, .current_bridge_out_b,
    .current_code, .current_ma);
  mdi_link_chk mdi_link_chk_inst (.clk_sys, .rst_b, .scl_m_oe(lnk.scl_m_oe), .sda_m_oe(lnk.sda_m_oe),
    .sda_t_oe(lnk.sda_t_oe), .scl(lnk.scl), .sda(lnk.sda));
  always #5 clk_sys = ~clk_sys;
  // count start pulses; index order follows the action numbers
  always @(posedge clk_sys) begin
    for (int i = 0; i < NUM_ACT; i++) begin
      if (act_v[i] === 1'b1) n_act[i] <= n_act[i] + 1;
    end
  end
  function automatic logic [31:0] nxt_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [8:0] exp_ma(input logic [3:0] c);
    return 9'h104 - 9'h00a * 9'(c);
  endfunction
  task automatic chk(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t %s", $time, what);
    end
  endtask
  // ------
  // host command and waits
  // ------
  task automatic xfer(input logic rd, input logic [7:0] rg, input logic [7:0] dt);
    int n;
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_reg <= rg;
    cmd_data <= dt;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (done !== 1'b1 && n < 2000);
    chk(done === 1'b1, "no done");
    chk(nack === 1'b0, "not acked");
    chk(cmd_ready === 1'b1, "not ready after done");
  endtask
  // pulses normally land before done, the limit only guards a late start
  task automatic wait_act(input int k, input int exp_n, input int lim);
    int n;
    n = 0;
    while (n_act[k] < exp_n && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk(n_act[k] == exp_n, "action start count");
  endtask
  task automatic close_out();
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    miscompares++;
    close_out();
  end
  initial begin
    logic [7:0] dt;
    logic b;
    int k;
    int exp_n [3];
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    chip_enable_pin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int c = 0; c < 16; c++) begin
      lfsr_q = nxt_rand(lfsr_q);
      xfer(1'b0, REG_CURRENT, {lfsr_q[7:4], 4'(c)});
      chk(current_code === 4'(c) && current_ma === exp_ma(4'(c)), "current");
    end
    xfer(1'b0, 8'h04 | lfsr_q[7:0], 8'h05);
    chk(current_code === 4'hf && current_ma === 9'h06e, "unknown pointer");
    for (int m = 0; m < 8; m++) begin
      lfsr_q = nxt_rand(lfsr_q);
      xfer(1'b0, REG_SHUTTER, {lfsr_q[7:3], 3'(m)});
      wait_act(ACT_SHUTTER, m + 1, SH_START_MAX_CYC);
      chk(shutter_mode === 2'(m) && shutter_on === m[2], "mode");
      chk(current_bridge_out_a === (m == 5) && current_bridge_out_b === (m == 6), "bridge");
    end
    for (int i = 0; i < 8; i++) begin
      lfsr_q = nxt_rand(lfsr_q);
      dt = lfsr_q[7:0];
      k = (i < 4) ? ACT_FOCUS : ACT_HOME;
      dt[(i < 4) ? FOCUS_ON_BIT : HOME_ON_BIT] = i[0];
      exp_n[k] = exp_n[k] + i[0];
      xfer(1'b0, (i < 4) ? REG_FOCUS : REG_HOME, dt);
      wait_act(k, exp_n[k], i[0] ? ((i < 4) ? FOCUS_START_MAX_CYC : HOME_START_MAX_CYC) : 0);
    end
    for (int i = 0; i < 6; i++) begin
      lfsr_q = nxt_rand(lfsr_q);
      b = (i < 2) ? i[0] : lfsr_q[0];
      seq_busy <= b;
      xfer(1'b1, lfsr_q[15:8], 8'h00);
      chk(rd_data === {b, 7'h00}, "status byte");
    end
    close_out();
  end
endmodule // motor_driver_i2c_target_tb
